// file: liu_mode_pkg.sv
`default_nettype none
package liu_mode_pkg;
  localparam int unsigned N_CH = 9;
  localparam int unsigned ADDR_W = 8;
  // Byte addresses, one aligned 32-bit word per register
  localparam logic [7:0] TERM_BASE = 8'h00;   // rx_termination_config, ch n at +4*n
  localparam logic [7:0] STD_BASE  = 8'h40;   // channel config, ch n at +4*n
  localparam logic [7:0] STAT_STD  = 8'h80;   // resolved line standard, 1 = E1
  localparam logic [7:0] STAT_SE   = 8'h84;   // resolved input mode, 1 = single ended
  localparam logic [7:0] STAT_MODE = 8'h88;   // matching mode, 2 bits per channel
  localparam logic [7:0] STAT_RES  = 8'h8C;   // internal resistor code, 2 bits per channel
  localparam logic [7:0] STAT_PINS = 8'h90;   // strap pin levels
  localparam logic [1:0] BANK_TERM = 2'h0;
  localparam logic [1:0] BANK_STD  = 2'h1;
  // Field positions
  localparam int unsigned TERM_RES_LSB = 0;
  localparam int unsigned TERM_EXT_BIT = 2;
  localparam int unsigned SE_BIT       = 3;
  localparam int unsigned FULL_BIT     = 4;
  localparam int unsigned STD_BIT      = 0;
  // Reset values
  localparam logic [7:0]  TERM_RST  = 8'h04;
  localparam logic [8:0]  STD_RST   = 9'h000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    MATCH_EXT  = 2'b00,
    MATCH_PART = 2'b01,
    MATCH_FULL = 2'b10
  } match_mode_t;
endpackage
`default_nettype wire

// file: liu_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface liu_cfg_if;
  logic                                  mode_open;
  logic                                  std_open;
  logic                                  force_high;
  logic [8:0]                            std_bits;
  logic [8:0][7:0]                       term_cfg;
  logic [8:0]                            tip;
  logic [8:0]                            ring;
  logic [8:0]                            std_e1;
  logic [8:0]                            single_ended;
  logic [8:0]                            rx_pos;
  logic [8:0]                            rx_neg;
  liu_mode_pkg::match_mode_t [8:0]       mode;
  logic [8:0][1:0]                       res;
  modport ctl (output mode_open, std_open, force_high, std_bits, term_cfg, tip, ring,
               input std_e1, single_ended, rx_pos, rx_neg, mode, res);
  modport dec (input mode_open, std_open, force_high, std_bits, term_cfg, tip, ring,
               output std_e1, single_ended, rx_pos, rx_neg, mode, res);
endinterface
`default_nettype wire

// file: liu_chan_decode.sv
`timescale 1ns/1ps
`default_nettype none
module liu_chan_decode (
  liu_cfg_if.dec cfg   // Pins and register fields in, resolved modes out
);
  for (genvar n = 0; n < 9; n++) begin : g_ch
    logic se;
    logic internal;
    // Open strap gives T1/J1, low gives E1
    assign cfg.std_e1[n] = cfg.mode_open ? ~cfg.std_open                  // see (R01)
                                         : cfg.std_bits[n];               // see (R02)
    assign se = cfg.term_cfg[n][liu_mode_pkg::SE_BIT];                    // see (R03)
    assign cfg.single_ended[n] = se;
    assign cfg.rx_pos[n] = cfg.tip[n];                                    // see (R04)
    assign cfg.rx_neg[n] = se ? 1'b0 : cfg.ring[n];                       // see (R04)
    // Force pin low overrides everything; single ended has no internal path
    assign internal = cfg.force_high & ~se                                // see (R05) (R06) (R07) (R12)
                    & ~cfg.term_cfg[n][liu_mode_pkg::TERM_EXT_BIT];       // see (R08) (R09)
    assign cfg.mode[n] = !internal ? liu_mode_pkg::MATCH_EXT
                       : cfg.term_cfg[n][liu_mode_pkg::FULL_BIT] ? liu_mode_pkg::MATCH_FULL
                       : liu_mode_pkg::MATCH_PART;                        // see (R10)
    assign cfg.res[n] = internal ? cfg.term_cfg[n][liu_mode_pkg::TERM_RES_LSB +: 2]
                                 : 2'h0;                                  // see (R11)
  end
endmodule
`default_nettype wire

// file: liu_mode_select.sv
// Summary of operation
// (R01) With the global mode pin open, every channel takes its standard from the standard pin (open T1/J1, low E1) and the channel bit is unused.
// (R02) With the global mode pin low, the standard pin is unused and each channel bit picks the standard, 0 for T1/J1 and 1 for E1.
// (R03) Bit 3 of each channel's termination config picks differential or single ended receive.
// (R04) Differential receive uses tip and ring, single ended uses tip alone.
// (R05) One impedance-force pin acts on all nine receivers at once, faster than register writes.
// (R06) While the force pin is low every receiver is in external matching and the code and full-internal bits are ignored.
// (R07) While the force pin is high each channel follows its own termination code and full-internal bit.
// (R08) Termination code bit 2 at 0 enables internal matching with the programmable resistor.
// (R09) Termination code bit 2 at 1 selects external matching and ignores bit 4 and code bits 1 to 0.
// (R10) With internal matching, bit 4 picks partial (0) or full (1) internal matching.
// (R11) With internal matching, code bits 1 to 0 set the internal resistor value.
// (R12) Single ended receive supports external matching only and ignores the termination code.
// (R13) Each channel has resolved standard, input mode and matching outputs derived combinationally.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module liu_mode_select (
  input  wire logic        i_core_clk,                     // 10 MHz clock
  input  wire logic        i_rst,                          // Sync reset, active high
  input  wire logic        i_ce,                           // Clock enable, freezes state
  input  wire logic [7:0]  i_avs_address,                  // Byte address
  input  wire logic        i_avs_read,                     // Read request
  input  wire logic        i_avs_write,                    // Write request
  input  wire logic [31:0] i_avs_writedata,                // Write data
  output logic [31:0]      o_avs_readdata,                 // Read data
  output logic             o_avs_waitrequest,              // Stall
  input  wire logic        i_global_mode_select_pin,       // 1 open, 0 low
  input  wire logic        i_global_line_standard_pin,     // 1 open, 0 low
  input  wire logic        i_rx_impedance_force_pin,       // 0 forces external match
  input  wire logic [8:0]  i_rx_tip_input,                 // Tip per channel
  input  wire logic [8:0]  i_rx_ring_input,                // Ring per channel
  output logic [8:0]       o_line_std_e1,                  // 1 E1, 0 T1/J1
  output logic [8:0]       o_single_ended,                 // 1 single ended
  output logic [17:0]      o_match_mode,                   // 2 bits per channel
  output logic [17:0]      o_internal_match_resistor,      // 2 bits per channel
  output logic [8:0]       o_rx_pos,                       // Tip path to receiver
  output logic [8:0]       o_rx_neg                        // Ring path, 0 if single ended
);
  liu_cfg_if cfg ();

  logic [8:0][7:0] term_q;
  logic [8:0]      std_q;
  logic            ack_q;
  logic [31:0]     rdata_q;
  logic            req;
  logic            wr_en;
  logic [3:0]      idx;
  logic            aligned;
  logic            idx_ok;
  logic [31:0]     rd_mux;

  // Bus slave: one wait cycle, then the request is taken
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~(ack_q & i_ce);
  assign wr_en             = i_avs_write & ack_q & i_ce;
  assign idx               = i_avs_address[5:2];
  assign aligned           = (i_avs_address[1:0] == 2'h0);
  assign idx_ok            = aligned && (idx < 4'(liu_mode_pkg::N_CH));

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= req & ~ack_q;
    end
  end

  for (genvar n = 0; n < 9; n++) begin : g_reg
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        term_q[n] <= liu_mode_pkg::TERM_RST;
        std_q[n]  <= liu_mode_pkg::STD_RST[n];
      end else if (wr_en && idx_ok && idx == 4'(n)) begin
        if (i_avs_address[7:6] == liu_mode_pkg::BANK_TERM) begin
          term_q[n] <= i_avs_writedata[7:0];
        end
        if (i_avs_address[7:6] == liu_mode_pkg::BANK_STD) begin
          std_q[n] <= i_avs_writedata[liu_mode_pkg::STD_BIT];
        end
      end
    end
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (idx_ok && i_avs_address[7:6] == liu_mode_pkg::BANK_TERM) begin
      rd_mux = {24'h00_0000, term_q[idx]};
    end else if (idx_ok && i_avs_address[7:6] == liu_mode_pkg::BANK_STD) begin
      rd_mux = {31'h0000_0000, std_q[idx]};
    end else begin
      unique case (i_avs_address)
        liu_mode_pkg::STAT_STD:  rd_mux = {23'h00_0000, cfg.std_e1};
        liu_mode_pkg::STAT_SE:   rd_mux = {23'h00_0000, cfg.single_ended};
        liu_mode_pkg::STAT_MODE: rd_mux = {14'h0000, cfg.mode};
        liu_mode_pkg::STAT_RES:  rd_mux = {14'h0000, cfg.res};
        liu_mode_pkg::STAT_PINS: rd_mux = {29'h0000_0000, i_rx_impedance_force_pin,
                                           i_global_line_standard_pin,
                                           i_global_mode_select_pin};
        default:                 rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q <= liu_mode_pkg::RDATA_RST;
    end else if (i_ce && i_avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end
  assign o_avs_readdata = rdata_q;

  assign cfg.mode_open  = i_global_mode_select_pin;
  assign cfg.std_open   = i_global_line_standard_pin;
  assign cfg.force_high = i_rx_impedance_force_pin;
  assign cfg.std_bits   = std_q;
  assign cfg.term_cfg   = term_q;
  assign cfg.tip        = i_rx_tip_input;
  assign cfg.ring       = i_rx_ring_input;

  liu_chan_decode u_decode (
    .cfg (cfg.dec)
  );

  // Outputs follow pins and fields with no register stage
  assign o_line_std_e1             = cfg.std_e1;          // see (R13)
  assign o_single_ended            = cfg.single_ended;
  assign o_match_mode              = cfg.mode;
  assign o_internal_match_resistor = cfg.res;
  assign o_rx_pos                  = cfg.rx_pos;
  assign o_rx_neg                  = cfg.rx_neg;

  global_std_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R01)
    i_global_mode_select_pin |-> o_line_std_e1 == {9{~i_global_line_standard_pin}})
    else $error("global standard not applied");

  chan_std_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R02)
    !i_global_mode_select_pin |-> o_line_std_e1 == std_q)
    else $error("channel standard bit not applied");

  se_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R03)
    wr_en && i_avs_address == liu_mode_pkg::TERM_BASE
    |=> o_single_ended[0] == $past(i_avs_writedata[liu_mode_pkg::SE_BIT]))
    else $error("single ended select not taken from write");

  rx_path_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R04)
    o_rx_pos == i_rx_tip_input && o_rx_neg == (i_rx_ring_input & ~o_single_ended))
    else $error("receive input routing wrong");

  force_ext_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R05) (R06)
    !i_rx_impedance_force_pin |-> o_match_mode == 18'h0_0000
                                  && o_internal_match_resistor == 18'h0_0000)
    else $error("force pin did not set all receivers external");

  for (genvar n = 0; n < 9; n++) begin : g_chk
    logic int_en;
    assign int_en = i_rx_impedance_force_pin && !term_q[n][liu_mode_pkg::SE_BIT]
                    && !term_q[n][liu_mode_pkg::TERM_EXT_BIT];

    int_match_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R07) (R08)
      int_en |-> o_match_mode[2*n +: 2] != liu_mode_pkg::MATCH_EXT)
      else $error("internal matching not enabled");

    ext_match_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R09)
      term_q[n][liu_mode_pkg::TERM_EXT_BIT] |-> o_match_mode[2*n +: 2] == liu_mode_pkg::MATCH_EXT
                                               && o_internal_match_resistor[2*n +: 2] == 2'h0)
      else $error("external matching not selected");

    full_sel_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R10)
      int_en |-> o_match_mode[2*n +: 2] == (term_q[n][liu_mode_pkg::FULL_BIT]
                 ? liu_mode_pkg::MATCH_FULL : liu_mode_pkg::MATCH_PART))
      else $error("full internal select wrong");

    res_code_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R11)
      int_en |-> o_internal_match_resistor[2*n +: 2] == term_q[n][1:0])
      else $error("internal resistor code wrong");

    se_ext_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R12)
      term_q[n][liu_mode_pkg::SE_BIT] |-> o_match_mode[2*n +: 2] == liu_mode_pkg::MATCH_EXT)
      else $error("single ended not external");
  end

  // Mode pin must be steady too, or a per-channel value may equal the new one
  comb_out_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R13)
    $changed(i_global_line_standard_pin) && i_global_mode_select_pin
    && $past(i_global_mode_select_pin)
    |-> o_line_std_e1 != $past(o_line_std_e1))
    else $error("standard output lags the pin");

  ce_freeze_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_ce |=> $stable(term_q) && $stable(std_q) && $stable(ack_q) && $stable(rdata_q))
    else $error("state moved while clock enable low");

  wait_first_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    req && !ack_q |-> o_avs_waitrequest)
    else $error("first request cycle not stalled");

  for (genvar n = 0; n < 9; n++) begin : g_wr_chk
    term_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R03)
      wr_en && i_avs_address == liu_mode_pkg::TERM_BASE + 8'(4 * n)
      |=> term_q[n] == $past(i_avs_writedata[7:0]))
      else $error("termination config write lost");

    std_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see (R02)
      wr_en && i_avs_address == liu_mode_pkg::STD_BASE + 8'(4 * n)
      |=> std_q[n] == $past(i_avs_writedata[liu_mode_pkg::STD_BIT]))
      else $error("channel standard write lost");
  end

  wait_one_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && req && !ack_q ##1 i_ce |-> !o_avs_waitrequest)
    else $error("slave did not answer after one wait cycle");
endmodule
`default_nettype wire

// file: liu_mode_and_rx_termination_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module liu_mode_and_rx_termination_select_tb;
  logic        clk  = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  adr  = 8'h00;
  logic        rd_q = 1'b0;
  logic        wr_q = 1'b0;
  logic [31:0] wd   = 32'h0;
  logic [31:0] rdata;
  logic        wait_r;
  logic        gm   = 1'b1;
  logic        gs   = 1'b1;
  logic        fp   = 1'b1;
  logic        ce   = 1'b1;
  logic [8:0]  tip  = 9'h000;
  logic [8:0]  ring = 9'h000;
  logic [8:0]  std_e1, se, rpos, rneg;
  logic [17:0] mm, res;
  logic [7:0]  cfg_m [9];
  logic [8:0]  std_m = 9'h000;
  logic [31:0] exp_q [$];
  logic [31:0] v;
  int          seed, error_cnt, total_checks, n;

  always #50 clk = ~clk;

  liu_mode_select DUT (
    .i_core_clk(clk), .i_rst(i_rst), .i_ce(ce), .i_avs_address(adr), .i_avs_read(rd_q),
    .i_avs_write(wr_q), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_global_mode_select_pin(gm),
    .i_global_line_standard_pin(gs), .i_rx_impedance_force_pin(fp), .i_rx_tip_input(tip),
    .i_rx_ring_input(ring), .o_line_std_e1(std_e1), .o_single_ended(se), .o_match_mode(mm),
    .o_internal_match_resistor(res), .o_rx_pos(rpos), .o_rx_neg(rneg));

  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; one idle edge keeps drivers apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a; wd <= d; wr_q <= w; rd_q <= ~w;
    do begin @(posedge clk); k++; end while (wait_r !== 1'b0 && k < 60);
    if (k >= 60) error_cnt++;
    rd_q <= 1'b0; wr_q <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  always @(posedge clk) begin
    if (rd_q === 1'b1 && wait_r === 1'b0) begin
      if (exp_q.size() == 0) error_cnt++;
      else chk(rdata, exp_q.pop_front());
    end
  end

  // Random clock-enable stalls stretch the bus wait
  always @(posedge clk) ce <= (($random(seed) & 3) != 0);

  // Single ended or force low pins external; bit 2 set is external too
  function automatic logic [1:0] mexp(input logic [7:0] c, input logic f);
    if (!f || c[3] || c[2]) return 2'h0;
    return c[4] ? 2'h2 : 2'h1;
  endfunction

  task automatic check_ports;
    logic [17:0] em, er;
    logic [8:0]  es;
    logic [8:0]  ed;
    @(negedge clk);
    for (int c = 0; c < 9; c++) begin
      em[2*c+:2] = mexp(cfg_m[c], fp);
      er[2*c+:2] = (em[2*c+:2] != 2'h0) ? cfg_m[c][1:0] : 2'h0;
      es[c]      = cfg_m[c][3];
    end
    ed = gm ? {9{~gs}} : std_m;
    chk(std_e1, ed);
    chk(se, es);
    chk(mm, em);
    chk(res, er);
    chk(rpos, tip);
    chk(rneg, ring & ~es);
    @(posedge clk);
    rd(liu_mode_pkg::STAT_MODE, {14'h0, em});
    rd(liu_mode_pkg::STAT_RES, {14'h0, er});
    rd(liu_mode_pkg::STAT_SE, {23'h0, es});
    rd(liu_mode_pkg::STAT_STD, {23'h0, ed});
    rd(liu_mode_pkg::STAT_PINS, {29'h0, fp, gs, gm});
  endtask

  initial begin
    seed = 32'hA8F7F7B1;
    for (int c = 0; c < 9; c++) cfg_m[c] = liu_mode_pkg::TERM_RST;
    repeat (5) @(posedge clk);
    i_rst <= 1'b0;
    @(posedge clk);
    rd(liu_mode_pkg::TERM_BASE, 32'h0000_0004);
    rd(liu_mode_pkg::STD_BASE, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    check_ports;
    bus(1'b1, liu_mode_pkg::STAT_MODE, 32'hFFFF_FFFF);
    bus(1'b1, 8'h24, 32'h0000_00FF);
    rd(8'h24, 32'h0000_0000);
    for (int k = 0; k < 60; k++) begin
      n = k % 9;
      v = $random(seed);
      if (k % 4 != 0) begin
        cfg_m[n] = v[7:0];
        bus(1'b1, liu_mode_pkg::TERM_BASE + 8'(4 * n), v);
        rd(liu_mode_pkg::TERM_BASE + 8'(4 * n), {24'h0, cfg_m[n]});
      end else begin
        std_m[n] = v[0];
        bus(1'b1, liu_mode_pkg::STD_BASE + 8'(4 * n), v);
      end
      gm <= v[8]; gs <= v[9]; fp <= v[10] | v[11]; tip <= v[20:12]; ring <= v[29:21];
      check_ports;
    end
    tally_and_finish;
  end

  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
